// ==== lcc_map.svh ====
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH
// Cell count of one cluster and table sizes.
`define LCC_CELLS 8
`define LCC_LUT4_BITS 16
`define LCC_LUT3_BITS 8
// Cell mode encodings.
`define LCC_MODE_NORMAL 2'h0
`define LCC_MODE_ARITH 2'h1
`define LCC_MODE_COUNT 2'h2
// Flip-flop reset value.
`define LCC_FF_RST 1'h0
`endif

// ==== lcc_pkg.sv ====
`default_nettype none
`include "lcc_map.svh"
package lcc_pkg;
  // Operating modes of one logic cell.
  typedef enum logic [1:0] {
    LCC_NORMAL = 2'h0,
    LCC_ARITH = 2'h1,
    LCC_COUNT = 2'h2
  } lcc_mode_t;

  // Configuration of one logic cell.
  typedef struct packed {
    lcc_mode_t mode;
    logic [15:0] lut;
    logic carry_as_in3;
    logic casc_en;
    logic reg_out;
    logic pack;
  } lcc_cfg_t;

  // Data and control inputs of one logic cell.
  typedef struct packed {
    logic [3:0] data;
    logic ena;
    logic clr;
    logic pre;
    logic cnt_en;
    logic up;
    logic sload;
  } lcc_in_t;

  // The two outputs of one logic cell.
  typedef struct packed {
    logic local_out;
    logic route_out;
  } lcc_out_t;
endpackage
`default_nettype wire

// ==== lcc_cluster.sv ====
`default_nettype none
`include "lcc_map.svh"
// Function
// R1: Cluster holds eight cells, one local interconnect.
// R2: Cell has table, flip-flop, carry, cascade.
// R3: Carry-in feeds table and next carry.
// R4: Long chains continue to cluster two away.
// R5: Chain breaks at mid-row RAM block.
// R6: Adder uses n plus one cells.
// R7: Output selects sum or registered value.
// R8: Cascade combines by AND, or OR inverted.
// R9: Each cascaded cell adds four inputs.
// R10: Normal mode four-input table, carry selectable.
// R11: Arithmetic mode two three-input tables.
// R12: Counter mode enables, direction, load paths.
// R13: Packing registers fourth input directly.
// R14: Chain start uses neutral cascade, constant carry.
// R15: Enabled flip-flop, clear/preset override clock; here both act only at the clock edge.
module lcc_cluster #(
  parameter int CELLS = `LCC_CELLS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Per-cell configuration and cluster-wide chain controls.
  input wire lcc_pkg::lcc_cfg_t cfg [CELLS],
  input wire logic casc_or,
  input wire logic chain_start,
  input wire logic carry_const,
  input wire logic chain_break,
  // Per-cell inputs.
  input wire lcc_pkg::lcc_in_t cell_in [CELLS],
  // Chains from the cluster two positions lower in the row.
  input wire logic carry_in,
  input wire logic casc_in,
  // Cell outputs.
  output lcc_pkg::lcc_out_t cell_out [CELLS],
  // Chains toward the cluster two positions higher in the row.
  output logic carry_out,
  output logic casc_out
);
  import lcc_pkg::*;

  logic [CELLS:0] carry_c;
  logic [CELLS:0] casc_c;
  logic [CELLS-1:0] ff_q;
  logic [CELLS-1:0] ff_d;
  logic [CELLS-1:0] comb_c;

  // At chain start the first cell takes a configured carry and the neutral cascade value. R14
  // The OR form carries inverted values, so neutral is one either way. R8
  assign carry_c[0] = chain_start ? carry_const : carry_in; // R3 R4 R14
  assign casc_c[0] = chain_start ? 1'h1 : (casc_or ? ~casc_in : casc_in); // R14

  // Mid-row breaks end the chain; the next cluster must start fresh. R5
  assign carry_out = chain_break ? 1'h0 : carry_c[CELLS]; // R4 R5
  assign casc_out = chain_break ? 1'h0 : (casc_or ? ~casc_c[CELLS] : casc_c[CELLS]); // R5 R8

  // Eight cells share the local inputs; the loop keeps them identical. R1 R2
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic [3:0] d;
    logic [3:0] idx4;
    logic [2:0] idx3;
    logic lut4_o;
    logic lut3_a;
    logic lut3_b;
    logic f_o;
    logic casc_v;
    assign d = cell_in[i].data;
    // Normal mode: fourth input is carry-in or fourth data input. R10
    assign idx4 = {cfg[i].carry_as_in3 ? carry_c[i] : d[3], d[2], d[1], d[0]}; // R10
    assign lut4_o = cfg[i].lut[idx4];
    // Arithmetic mode: two three-input tables on carry and data; counter mode on carry, up and register. R11
    assign idx3 = (cfg[i].mode == LCC_COUNT) ? {carry_c[i], cell_in[i].up, ff_q[i]}
                                             : {carry_c[i], d[1], d[0]}; // R3 R11 R12
    assign lut3_a = cfg[i].lut[idx3]; // R11
    assign lut3_b = cfg[i].lut[{1'h1, idx3}]; // R11
    assign f_o = (cfg[i].mode == LCC_NORMAL) ? lut4_o : lut3_a;
    // Cascade AND on true values; OR uses inverted inputs and output. R8 R9
    assign casc_v = casc_or ? ~f_o : f_o;
    assign casc_c[i+1] = cfg[i].casc_en ? (casc_c[i] & casc_v) : casc_c[i]; // R8 R9
    assign comb_c[i] = cfg[i].casc_en ? (casc_or ? ~casc_c[i+1] : casc_c[i+1]) : f_o;
    // Carry-out from the second table; normal mode passes carry through, a counter with cnt_en low gives zero. R3 R6
    assign carry_c[i+1] = (cfg[i].mode == LCC_NORMAL) ? carry_c[i]
                          : (cfg[i].mode == LCC_COUNT && !cell_in[i].cnt_en) ? 1'h0
                          : lut3_b; // R6 R12

    // Next flip-flop value: packed data, sync load, counter hold or table. R12 R13
    always_comb begin
      if (cfg[i].pack) begin
        ff_d[i] = d[3]; // R13
      end else if (cfg[i].mode == LCC_COUNT && cell_in[i].sload) begin
        ff_d[i] = d[2]; // R12
      end else if (cfg[i].mode == LCC_COUNT && !cell_in[i].cnt_en) begin
        ff_d[i] = ff_q[i]; // R12
      end else begin
        ff_d[i] = comb_c[i];
      end
    end

    // Clear and preset win over the enable at the clock edge; clear wins over preset. R15
    // Sampling is synchronous here, a trade made for single-clock timing.
    always_ff @(posedge clk) begin
      if (!resetn) begin
        ff_q[i] <= `LCC_FF_RST;
      end else if (cell_in[i].clr) begin
        ff_q[i] <= 1'h0; // R12 R15
      end else if (cell_in[i].pre) begin
        ff_q[i] <= 1'h1; // R12 R15
      end else if (cell_in[i].ena) begin
        ff_q[i] <= ff_d[i]; // R15
      end
    end

    // Packed cells drive route from the register and local from the table. R7 R13
    always_comb begin
      if (cfg[i].pack) begin
        cell_out[i].route_out = ff_q[i]; // R13
        cell_out[i].local_out = comb_c[i]; // R13
      end else begin
        cell_out[i].route_out = cfg[i].reg_out ? ff_q[i] : comb_c[i]; // R7
        cell_out[i].local_out = cfg[i].reg_out ? ff_q[i] : comb_c[i]; // R7
      end
    end
  end
endmodule
`default_nettype wire

// ==== lcc_nbr.sv ====
`default_nettype none
// Lower neighbour cluster; its chain outputs flip every cycle so a stale carry shows at once.
module lcc_nbr (
  input wire logic clk,
  output logic carry_out = 1'h0,
  output logic casc_out = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only this process drives the outputs; the declarations give them known start levels.
  always @(posedge clk) #2 {carry_out, casc_out} = ~{carry_out, casc_out};
endmodule
`default_nettype wire

// ==== lcc_cluster_monitor.sv ====
`default_nettype none
// Cell 0 and chain-end checks; sums are judged only while the cluster starts its own chain.
module lcc_mon #(parameter int CELLS = 8) (
  input wire logic clk,
  input wire logic resetn,
  input wire lcc_pkg::lcc_cfg_t cfg [CELLS],
  input wire logic chain_start,
  input wire logic carry_const,
  input wire logic chain_break,
  input wire lcc_pkg::lcc_in_t cell_in [CELLS],
  input wire lcc_pkg::lcc_out_t cell_out [CELLS],
  input wire logic carry_out,
  input wire logic casc_out
);
  import lcc_pkg::*;
  logic a0, c0r, s0, o0;
  logic [2:0] k0;
  // Cell 0 as an adder bit, plain or registered; k0 holds its ena, clr and pre.
  always_comb begin
    a0 = chain_start && cfg[0] == {LCC_ARITH, 16'he896, 4'h0};
    c0r = chain_start && cfg[0] == {LCC_ARITH, 16'he896, 4'h2};
    s0 = cell_in[0].data[0] ^ cell_in[0].data[1] ^ carry_const;
    {o0, k0} = {cell_out[0].route_out, cell_in[0][5:3]};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Registered cell 0 sees control k, then stays registered for one more edge.
  sequence held(k);
    c0r && k ##1 c0r;
  endsequence
  AST_BRK: assert property (chain_break |-> !carry_out) else $error("carry past break");
  AST_CSC: assert property (chain_break |-> !casc_out) else $error("cascade past break");
  AST_SUM: assert property (a0 |-> cell_out[0].local_out == s0) else $error("sum");
  AST_LOC: assert property (c0r |-> cell_out[0].local_out == o0) else $error("outputs");
  AST_CLR: assert property (held(k0[1]) |-> !o0) else $error("clear");
  AST_PRE: assert property (held(k0[1:0] == 2'h1) |-> o0) else $error("preset");
  AST_HLD: assert property (held(k0 == 3'h0) |-> $stable(o0)) else $error("hold");
  AST_ACC: assert property (held(k0 == 3'h4) |-> o0 == $past(s0)) else $error("accumulate");
endmodule
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcc_pkg::*;
  logic clk = 1'h0, resetn = 1'h0, cs = 1'h1, cc = 1'h0, brk = 1'h0, rg = 1'h0, ci, di, co, dq;
  logic cz = 1'h0;
  logic [7:0] a = 8'h0, b = 8'h0, q = 8'h0, nq = 8'h0, rt;
  logic [2:0] ctl = 3'h4;
  logic [8:0] s;
  int seed = 32'hfbb95937, failures = 0, checked = 0, cycles = 0;
  lcc_cfg_t cfg [8];
  lcc_in_t cell_in [8];
  lcc_out_t cell_out [8];
  // Every cell is an adder bit, or in the cascade phase a four-input AND on a cascade.
  // ctl gives ena, clr and pre to all cells at once.
  always_comb for (int i = 0; i < 8; i++) begin
    cfg[i] = cz ? {LCC_NORMAL, 16'h8000, 4'h4} : {LCC_ARITH, 16'he896, 2'h0, rg, 1'h0};
    cell_in[i] = {cz ? {4{a[i]}} : {2'h0, b[i], a[i]}, ctl, 3'h0};
    rt[i] = cell_out[i].route_out;
  end
  lcc_cluster lcc_cluster_i (.clk, .resetn, .cfg, .casc_or(rg & !cz), .chain_start(cs),
    .carry_const(cc),
    .chain_break(brk), .cell_in, .carry_in(ci), .casc_in(di), .cell_out, .carry_out(co),
    .casc_out(dq));
  lcc_nbr lcc_nbr_i (.clk, .carry_out(ci), .casc_out(di));
  // Carry source follows chain start, so the neighbour's toggling carry is exercised too.
  function automatic logic [8:0] add(input logic [7:0] x, y);
    return {1'h0, x} + y + (cs ? cc : ci);
  endfunction
  task automatic chk(input logic [8:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  // A hang is cut off far beyond the planned few hundred cycles.
  always @(posedge clk) if (++cycles == 1000) begin
    failures++;
    wrap_up();
  end
  // Random operands and controls; the first four cycles of each phase put all ones on a, with b at 0 or 1, for long carries and a true AND.
  initial begin
    repeat (8) @(posedge clk);
    #2 resetn = 1'h1;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      #2 q = nq;
      cz = n >= 300;
      {a, b, ctl, rg, cs, cc} = 22'($random(seed));
      if (n % 300 < 4) {a, b, ctl} = {8'hff, 7'h0, n[0], 3'h4};
      brk = n % 5 == 1;
      #5 s = add(a, b);
      if (!cz) chk(rg ? q : s[7:0], rt);
      if (cz) chk(9'((cs || di) && &a), 9'(rt[7]));
      chk(brk ? 9'h0 : cz ? 9'(cs ? cc : ci) : s[8], co);
      chk(brk ? 9'h0 : 9'(cz ? (cs || di) && &a : cs ? !rg : di), dq);
      nq = ctl[1] ? 8'h0 : ctl[0] ? 8'hff : ctl[2] ? s[7:0] : q;
    end
    wrap_up();
  end
endmodule
bind lcc_cluster lcc_mon #(.CELLS(CELLS)) lcc_mon_i (.clk, .resetn, .cfg, .chain_start,
  .carry_const, .chain_break, .cell_in, .cell_out, .carry_out, .casc_out);
`default_nettype wire
